//--- fsh_host.sv
// host-side sequencer driving a parallel sector flash through its strobe pins
//
// Notes on behaviour
// R1: three unlock writes precede every sector byte load.
// R2: all 256 sector bytes are loaded in one sequence with write strobes.
// R3: bytes not loaded in the sector become undefined after programming.
// R4: sector address stays on upper lines at every byte-load write edge.
// R5: output enable stays high whenever write enable and chip enable are low.
// R6: byte loads follow within 150 us; longer gap starts the program cycle.
// R7: commands decode only low fifteen address bits and eight data bits.
// R8: identification entry is AA at 5555, 55 at 2AAA, 90 at 5555.
// R9: wait 20 ms after identification entry before reading identification data.
// R10: identification reads at address 0 give maker, address 1 part code.
// R11: power loss leaves identification mode; power-up reads the array.
// R12: the exit sequence returns the device to array reads.
// R13: reads during programming return toggle status.
// R14: toggle bit alternates while busy; first and last values are arbitrary.
// R15: polling reads keep one constant address.
// R16: lockout sequence has separate data variants for low and high boot block.
// R17: boot blocks are lowest and highest 16K bytes, locked independently.
// R18: identification reads at 00002 and 7FFF2 show lock state FE or FF.
// R19: locked blocks refuse erase and program; chip erase then refused.
// R20: reads show busy status until the internal cycle completes.
// R21: malformed command sequences are ignored by the device.
`timescale 1ns/100ps
`default_nettype none
module fsh_host #(
	parameter int ID_WAIT_CYC      = fsh_pkg::ID_WAIT_CYC,
	parameter int PROG_TIMEOUT_CYC = fsh_pkg::TWC_CYC,
	parameter int BUF_DEPTH        = 2
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [2:0]  cmd_op,
	input  wire logic [18:0] cmd_addr,
	input  wire logic        wr_valid,
	output logic             wr_ready,
	input  wire logic [7:0]  wr_data,
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [7:0]       rd_data,
	output logic             busy,
	output logic             done,
	output logic             err,
	output logic [18:0]      fl_addr,
	output logic             fl_ce_n,
	output logic             fl_oe_n,
	output logic             fl_we_n,
	output logic [7:0]       fl_dq_o,
	output logic             fl_dq_oe,
	input  wire logic [7:0]  fl_dq_i
);
	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	generate
		if (ID_WAIT_CYC < 1 || ID_WAIT_CYC >= (1 << 20)
			|| PROG_TIMEOUT_CYC < 1 || PROG_TIMEOUT_CYC >= (1 << 20))
		begin : g_bad_count
			$error("fsh_host wait counts must lie between 1 and 2**20-1");
		end
	endgenerate

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		fsh_pkg::fsh_st_e st;
		fsh_pkg::fsh_ph_e ph;
		logic [2:0]       op;
		logic [3:0]       step;
		logic [8:0]       idx;
		logic [10:0]      sec;
		logic [19:0]      tmr;
		logic [19:0]      wd;
		logic [18:0]      addr;
		logic [7:0]       dq;
		logic             ce_n;
		logic             oe_n;
		logic             we_n;
		logic             dq_oe;
		logic [7:0]       s1;
		logic [7:0]       s2;
		logic [7:0]       s3;
		logic [7:0]       stab;
		logic             tog;
		logic             have;
		logic             same;
		logic             done;
		logic             err;
		logic [7:0]       rdat;
		logic             rpush;
	} fsh_state_s;

	localparam fsh_state_s RST_VAL = '{st: fsh_pkg::ST_IDLE, ph: fsh_pkg::PH_WAIT,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};

	fsh_state_s  cur_ff;
	fsh_state_s  nxt_ff;
	logic        buf_in_ready;
	logic        is_wr;
	logic        fin;
	logic        cap;
	logic [19:0] low_len;
	logic [19:0] high_len;
	logic [22:0] w;
	logic [22:0] w0;

	assign cmd_ready = (cur_ff.st == fsh_pkg::ST_IDLE);
	assign wr_ready  = (cur_ff.st == fsh_pkg::ST_LOAD) && (cur_ff.ph == fsh_pkg::PH_WAIT);
	assign busy      = (cur_ff.st != fsh_pkg::ST_IDLE);
	assign done      = cur_ff.done;
	assign err       = cur_ff.err;
	assign fl_addr   = cur_ff.addr;
	assign fl_ce_n   = cur_ff.ce_n;
	assign fl_oe_n   = cur_ff.oe_n;
	assign fl_we_n   = cur_ff.we_n;
	assign fl_dq_o   = cur_ff.dq;
	assign fl_dq_oe  = cur_ff.dq_oe;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_ff       = cur_ff;
		nxt_ff.done  = 1'b0;
		nxt_ff.err   = 1'b0;
		nxt_ff.rpush = 1'b0;
		// pins are asynchronous to mclk: accept a value once two stages agree
		nxt_ff.s1 = fl_dq_i;
		nxt_ff.s2 = cur_ff.s1;
		nxt_ff.s3 = cur_ff.s2;
		if (cur_ff.s2 == cur_ff.s3)
			nxt_ff.stab = cur_ff.s3;

		is_wr    = (cur_ff.st == fsh_pkg::ST_CMD) || (cur_ff.st == fsh_pkg::ST_LOAD);
		low_len  = is_wr ? 20'(fsh_pkg::TWP_CYC) : 20'(fsh_pkg::RD_LOW_CYC);
		high_len = is_wr ? 20'(fsh_pkg::TWPH_CYC) : 20'(fsh_pkg::TOEHP_CYC);
		fin      = 1'b0;
		cap      = 1'b0;
		w        = fsh_pkg::seq_word(cur_ff.op, cur_ff.step + 4'h1);
		w0       = fsh_pkg::seq_word(cmd_op, 4'h0);

		// one strobe cycle: address set-up, strobe low, strobe high
		if (cur_ff.st == fsh_pkg::ST_CMD || cur_ff.st == fsh_pkg::ST_LOAD
			|| cur_ff.st == fsh_pkg::ST_POLL || cur_ff.st == fsh_pkg::ST_RD)
		begin
			case (cur_ff.ph)
				fsh_pkg::PH_SET:
				begin
					nxt_ff.ph  = fsh_pkg::PH_LOW;
					nxt_ff.tmr = '0;
					if (is_wr) // R5
						nxt_ff.we_n = 1'b0;
					else
						nxt_ff.oe_n = 1'b0;
				end
				fsh_pkg::PH_LOW:
				begin
					nxt_ff.tmr = cur_ff.tmr + 20'h00001;
					if (cur_ff.tmr == low_len - 20'h00001)
					begin
						nxt_ff.we_n = 1'b1;
						nxt_ff.oe_n = 1'b1;
						nxt_ff.ph   = fsh_pkg::PH_HIGH;
						nxt_ff.tmr  = '0;
						cap         = !is_wr;
					end
				end
				fsh_pkg::PH_HIGH:
				begin
					nxt_ff.tmr = cur_ff.tmr + 20'h00001;
					if (cur_ff.tmr == high_len - 20'h00001)
					begin
						fin        = 1'b1;
						nxt_ff.tmr = '0;
						nxt_ff.ph  = fsh_pkg::PH_WAIT;
					end
				end
				default: ;
			endcase
		end

		case (cur_ff.st)
			fsh_pkg::ST_IDLE:
			begin
				nxt_ff.ce_n  = 1'b1;
				nxt_ff.oe_n  = 1'b1;
				nxt_ff.we_n  = 1'b1;
				nxt_ff.dq_oe = 1'b0;
				if (cmd_valid)
				begin
					nxt_ff.op   = cmd_op;
					nxt_ff.sec  = cmd_addr[18:8];
					nxt_ff.step = '0;
					nxt_ff.idx  = '0;
					nxt_ff.wd   = '0;
					nxt_ff.ce_n = 1'b0;
					case (cmd_op)
						fsh_pkg::OP_READ:
						begin
							nxt_ff.st   = fsh_pkg::ST_RD;
							nxt_ff.ph   = fsh_pkg::PH_WAIT;
							nxt_ff.addr = cmd_addr;
						end
						fsh_pkg::OP_PROGRAM, fsh_pkg::OP_ID_ENTER, fsh_pkg::OP_ID_EXIT,
						fsh_pkg::OP_LOCK_LOW, fsh_pkg::OP_LOCK_HIGH:
						begin
							// only the low fifteen bits carry a command address
							nxt_ff.st    = fsh_pkg::ST_CMD; // R1 R8 R16
							nxt_ff.ph    = fsh_pkg::PH_SET;
							nxt_ff.addr  = {4'h0, w0[22:8]}; // R7
							nxt_ff.dq    = w0[7:0];
							nxt_ff.dq_oe = 1'b1;
						end
						default:
						begin
							nxt_ff.err  = 1'b1;
							nxt_ff.ce_n = 1'b1;
						end
					endcase
				end
			end
			fsh_pkg::ST_CMD:
			begin
				if (fin)
				begin
					nxt_ff.dq_oe = 1'b0;
					if (cur_ff.step == fsh_pkg::seq_len(cur_ff.op) - 4'h1)
					begin
						nxt_ff.tmr = '0;
						case (cur_ff.op)
							fsh_pkg::OP_PROGRAM:  nxt_ff.st = fsh_pkg::ST_LOAD; // R1
							fsh_pkg::OP_ID_ENTER: nxt_ff.st = fsh_pkg::ST_PAUSE; // R9
							fsh_pkg::OP_ID_EXIT:
							begin
								nxt_ff.st   = fsh_pkg::ST_IDLE;
								nxt_ff.done = 1'b1;
								nxt_ff.ce_n = 1'b1;
							end
							default: nxt_ff.st = fsh_pkg::ST_SETTLE;
						endcase
					end
					else
					begin
						nxt_ff.step  = cur_ff.step + 4'h1;
						nxt_ff.ph    = fsh_pkg::PH_SET;
						nxt_ff.addr  = {4'h0, w[22:8]}; // R7 R8 R16
						nxt_ff.dq    = w[7:0];
						nxt_ff.dq_oe = 1'b1;
					end
				end
			end
			fsh_pkg::ST_LOAD:
			begin
				if (cur_ff.ph == fsh_pkg::PH_WAIT && !fin)
				begin
					nxt_ff.wd = cur_ff.wd + 20'h00001;
					if (wr_valid)
					begin
						nxt_ff.addr  = {cur_ff.sec, cur_ff.idx[7:0]}; // R4
						nxt_ff.dq    = wr_data;
						nxt_ff.dq_oe = 1'b1;
						nxt_ff.ph    = fsh_pkg::PH_SET;
						nxt_ff.wd    = '0;
					end
					else if (cur_ff.wd == 20'(fsh_pkg::GAP_LIM))
					begin
						// a late source would let the device start on a partial sector
						nxt_ff.err = 1'b1; // R6
						nxt_ff.st  = fsh_pkg::ST_SETTLE;
						nxt_ff.tmr = '0;
					end
				end
				if (fin)
				begin
					nxt_ff.dq_oe = 1'b0;
					nxt_ff.idx   = cur_ff.idx + 9'h001;
					nxt_ff.wd    = '0;
					if (cur_ff.idx == 9'(fsh_pkg::SECTOR_BYTES - 1))
					begin
						nxt_ff.st  = fsh_pkg::ST_SETTLE; // R2
						nxt_ff.tmr = '0;
					end
				end
			end
			fsh_pkg::ST_SETTLE:
			begin
				// let the load window expire so the internal cycle has started
				nxt_ff.tmr = cur_ff.tmr + 20'h00001;
				if (cur_ff.tmr == 20'(fsh_pkg::BLC_MAX_CYC))
				begin
					nxt_ff.st   = fsh_pkg::ST_POLL; // R6
					nxt_ff.ph   = fsh_pkg::PH_SET;
					nxt_ff.have = 1'b0;
					nxt_ff.same = 1'b0;
					nxt_ff.wd   = '0;
					if (cur_ff.op == fsh_pkg::OP_PROGRAM)
						nxt_ff.addr = {cur_ff.sec, 8'h00};
					else
						nxt_ff.addr = 19'h00000;
				end
			end
			fsh_pkg::ST_POLL:
			begin
				nxt_ff.wd = cur_ff.wd + 20'h00001;
				if (cap)
				begin
					// the first sample only seeds the comparison
					nxt_ff.tog  = cur_ff.stab[fsh_pkg::TOGGLE_BIT]; // R14
					nxt_ff.have = 1'b1;
					nxt_ff.same = cur_ff.have && (cur_ff.stab[fsh_pkg::TOGGLE_BIT] == cur_ff.tog);
				end
				if (fin)
				begin
					if (cur_ff.same)
					begin
						nxt_ff.st   = fsh_pkg::ST_IDLE;
						nxt_ff.done = 1'b1;
						nxt_ff.ce_n = 1'b1;
					end
					else if (cur_ff.wd >= 20'(PROG_TIMEOUT_CYC - 1))
					begin
						nxt_ff.st   = fsh_pkg::ST_IDLE;
						nxt_ff.err  = 1'b1;
						nxt_ff.ce_n = 1'b1;
					end
					else
						nxt_ff.ph = fsh_pkg::PH_SET; // R15
				end
			end
			fsh_pkg::ST_PAUSE:
			begin
				nxt_ff.tmr = cur_ff.tmr + 20'h00001;
				if (cur_ff.tmr == 20'(ID_WAIT_CYC - 1))
				begin
					nxt_ff.st   = fsh_pkg::ST_IDLE; // R9
					nxt_ff.done = 1'b1;
					nxt_ff.ce_n = 1'b1;
				end
			end
			fsh_pkg::ST_RD:
			begin
				// hold off the strobe while the buffer has no room for the answer
				if (cur_ff.ph == fsh_pkg::PH_WAIT && !fin && buf_in_ready)
					nxt_ff.ph = fsh_pkg::PH_SET;
				if (cap)
				begin
					nxt_ff.rdat  = cur_ff.stab;
					nxt_ff.rpush = 1'b1;
				end
				if (fin)
				begin
					nxt_ff.st   = fsh_pkg::ST_IDLE;
					nxt_ff.done = 1'b1;
					nxt_ff.ce_n = 1'b1;
				end
			end
			default: nxt_ff = RST_VAL;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			cur_ff <= RST_VAL;
		else
			cur_ff <= nxt_ff;
	end

	fsh_buf #(
		.W     (8),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.mclk      (mclk),
		.srst      (srst),
		.in_valid  (cur_ff.rpush),
		.in_ready  (buf_in_ready),
		.in_data   (cur_ff.rdat),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence we_low_s;
		(!fl_we_n)[*5];
	endsequence
	sequence we_high_s;
		fl_we_n[*5];
	endsequence

	oe_while_write_a: assert property (!fl_we_n |-> fl_oe_n) // R5
		else $error("output enable low during a write strobe");
	write_pulse_a: assert property ($fell(fl_we_n) |-> we_low_s ##1 we_high_s) // R2
		else $error("write strobe shape wrong");
	unlock_before_load_a: assert property ( // R1
		(cur_ff.st == fsh_pkg::ST_LOAD && $past(cur_ff.st) != fsh_pkg::ST_LOAD)
		|-> ($past(cur_ff.step) == 4'h2 && cur_ff.op == fsh_pkg::OP_PROGRAM))
		else $error("byte load entered without the unlock writes");
	full_sector_a: assert property ( // R2
		($past(cur_ff.st) == fsh_pkg::ST_LOAD && cur_ff.st == fsh_pkg::ST_SETTLE && !err)
		|-> cur_ff.idx == 9'h100)
		else $error("sector load ended early");
	load_gap_a: assert property ((cur_ff.st == fsh_pkg::ST_LOAD) // R6
		|-> cur_ff.wd <= 20'(fsh_pkg::GAP_LIM))
		else $error("byte load gap too long");
	sector_addr_a: assert property ( // R4
		($fell(fl_we_n) && cur_ff.st == fsh_pkg::ST_LOAD) |-> fl_addr[18:8] == cur_ff.sec)
		else $error("sector address wrong at byte load");
	id_entry_a: assert property ( // R8
		($fell(fl_we_n) && cur_ff.st == fsh_pkg::ST_CMD && cur_ff.op == fsh_pkg::OP_ID_ENTER)
		|-> fl_dq_oe && (fl_addr[14:0] == ((cur_ff.step == 4'h1) ? 15'h2aaa : 15'h5555))
		&& (fl_dq_o == ((cur_ff.step == 4'h0) ? 8'haa : (cur_ff.step == 4'h1) ? 8'h55 : 8'h90)))
		else $error("identification entry write wrong");
	id_pause_a: assert property ( // R9
		($past(cur_ff.st) == fsh_pkg::ST_PAUSE && cur_ff.st == fsh_pkg::ST_IDLE)
		|-> $past(cur_ff.tmr) == 20'(ID_WAIT_CYC - 1))
		else $error("identification pause cut short");
	poll_addr_a: assert property ( // R15
		(cur_ff.st == fsh_pkg::ST_POLL && $past(cur_ff.st) == fsh_pkg::ST_POLL)
		|-> $stable(fl_addr))
		else $error("polling address moved");
	lock_variant_a: assert property ( // R16
		($fell(fl_we_n) && cur_ff.st == fsh_pkg::ST_CMD && cur_ff.step == 4'h6)
		|-> fl_dq_o == ((cur_ff.op == fsh_pkg::OP_LOCK_HIGH) ? 8'hff : 8'h00))
		else $error("lockout data variant wrong");

endmodule : fsh_host
`default_nettype wire

//--- fsh_pkg.sv
// constants, enumerations and command tables shared by the flash host controller
`default_nettype none
package fsh_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_NS      = 40;
	localparam int TAS_NS      = 10;
	localparam int TWP_NS      = 200;
	localparam int TWPH_NS     = 200;
	localparam int TACC_NS     = 150;
	localparam int TOEHP_NS    = 150;
	localparam int BLC_US      = 150;
	localparam int ID_PAUSE_MS = 20;
	localparam int TWC_MS      = 20;
	localparam int SYNC_CYC    = 3;

	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	function automatic int cyc_dn(input int ns);
		int c;
		c = ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_dn

	localparam int TAS_CYC     = cyc_up(TAS_NS);
	localparam int TWP_CYC     = cyc_up(TWP_NS);
	localparam int TWPH_CYC    = cyc_up(TWPH_NS);
	localparam int TACC_CYC    = cyc_up(TACC_NS);
	localparam int TOEHP_CYC   = cyc_up(TOEHP_NS);
	// output enable stays low until the data has crossed the input synchroniser
	localparam int RD_LOW_CYC  = TACC_CYC + SYNC_CYC + 2;
	localparam int BLC_MAX_CYC = cyc_dn(BLC_US * 1000);
	localparam int WR_CYC      = TAS_CYC + TWP_CYC + TWPH_CYC;
	localparam int GAP_LIM     = BLC_MAX_CYC - WR_CYC;
	localparam int ID_WAIT_CYC = cyc_dn(ID_PAUSE_MS * 1000000);
	localparam int TWC_CYC     = cyc_dn(TWC_MS * 1000000);

	// ---------------------------------------------------------------
	// array geometry and command codes
	// ---------------------------------------------------------------
	localparam int SECTOR_BYTES   = 256;
	localparam int TOGGLE_BIT     = 6;
	localparam logic [14:0] CMD_ADDR_A = 15'h5555;
	localparam logic [14:0] CMD_ADDR_B = 15'h2aaa;
	localparam logic [14:0] LOCK_ADDR  = 15'h0000;
	localparam logic [7:0] UNLOCK_1       = 8'haa;
	localparam logic [7:0] UNLOCK_2       = 8'h55;
	localparam logic [7:0] ID_ENTRY_CMD   = 8'h90;
	localparam logic [7:0] PROG_CMD       = 8'ha0;
	localparam logic [7:0] ID_EXIT_CMD    = 8'hf0;
	localparam logic [7:0] LOCK_CMD_1     = 8'h80;
	localparam logic [7:0] LOCK_CMD_2     = 8'h40;
	localparam logic [7:0] LOCK_LOW_DATA  = 8'h00;
	localparam logic [7:0] LOCK_HIGH_DATA = 8'hff;

	localparam logic [2:0] OP_READ      = 3'h0;
	localparam logic [2:0] OP_PROGRAM   = 3'h1;
	localparam logic [2:0] OP_ID_ENTER  = 3'h2;
	localparam logic [2:0] OP_ID_EXIT   = 3'h3;
	localparam logic [2:0] OP_LOCK_LOW  = 3'h4;
	localparam logic [2:0] OP_LOCK_HIGH = 3'h5;

	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD, ST_LOAD, ST_SETTLE, ST_POLL, ST_PAUSE, ST_RD
	} fsh_st_e;

	typedef enum logic [1:0] {PH_WAIT, PH_SET, PH_LOW, PH_HIGH} fsh_ph_e;

	// ---------------------------------------------------------------
	// command write tables
	// ---------------------------------------------------------------
	function automatic logic [3:0] seq_len(input logic [2:0] op);
		case (op)
			OP_PROGRAM, OP_ID_ENTER, OP_ID_EXIT: return 4'h3;
			OP_LOCK_LOW, OP_LOCK_HIGH:           return 4'h7;
			default:                             return 4'h0;
		endcase
	endfunction : seq_len

	// returns {command address, data}
	function automatic logic [22:0] seq_word(input logic [2:0] op, input logic [3:0] step);
		case (step)
			4'h0: return {CMD_ADDR_A, UNLOCK_1};
			4'h1: return {CMD_ADDR_B, UNLOCK_2};
			4'h2:
			begin
				case (op)
					OP_PROGRAM:  return {CMD_ADDR_A, PROG_CMD};
					OP_ID_ENTER: return {CMD_ADDR_A, ID_ENTRY_CMD};
					OP_ID_EXIT:  return {CMD_ADDR_A, ID_EXIT_CMD};
					default:     return {CMD_ADDR_A, LOCK_CMD_1};
				endcase
			end
			4'h3: return {CMD_ADDR_A, UNLOCK_1};
			4'h4: return {CMD_ADDR_B, UNLOCK_2};
			4'h5: return {CMD_ADDR_A, LOCK_CMD_2};
			default: return {LOCK_ADDR, (op == OP_LOCK_HIGH) ? LOCK_HIGH_DATA : LOCK_LOW_DATA};
		endcase
	endfunction : seq_word

endpackage : fsh_pkg
`default_nettype wire

//--- fsh_buf.sv
// small valid/ready buffer for read data
`timescale 1ns/100ps
`default_nettype none
module fsh_buf #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("fsh_buf depth must be a power of two of at least two");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fsh_buf_s;

	fsh_buf_s cur_ff;
	fsh_buf_s nxt_ff;
	logic     push;
	logic     pop;

	assign in_ready  = (cur_ff.cnt != (AW+1)'(DEPTH));
	assign out_valid = (cur_ff.cnt != '0);
	assign out_data  = cur_ff.mem[cur_ff.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		nxt_ff = cur_ff;
		if (push)
		begin
			nxt_ff.mem[cur_ff.wp] = in_data;
			nxt_ff.wp             = cur_ff.wp + 1'b1;
		end
		if (pop)
			nxt_ff.rp = cur_ff.rp + 1'b1;
		case ({push, pop})
			2'b10:   nxt_ff.cnt = cur_ff.cnt + 1'b1;
			2'b01:   nxt_ff.cnt = cur_ff.cnt - 1'b1;
			default: nxt_ff.cnt = cur_ff.cnt;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			cur_ff <= '{default: '0};
		else
			cur_ff <= nxt_ff;
	end

endmodule : fsh_buf
`default_nettype wire

//--- fsh_flash_model.sv
// behavioural sector flash device answering the host controller's strobes
`timescale 1ns/100ps
`default_nettype none
module fsh_flash_model #(
	parameter logic [7:0] MAKER   = 8'h3a, // arbitrary value
	parameter logic [7:0] PART    = 8'h7b, // arbitrary value
	parameter realtime    BLC_NS  = 150000,
	parameter realtime    PROG_NS = 2000,
	parameter realtime    ID_NS   = 800
) (
	input  wire logic [18:0] fl_addr,
	input  wire logic        fl_ce_n,
	input  wire logic        fl_oe_n,
	input  wire logic        fl_we_n,
	input  wire logic [7:0]  fl_dq_o,
	output logic [7:0]       fl_dq_i,
	output logic             viol
);
	// --------------------
	// device state
	// --------------------
	logic [7:0]  mem [int];
	logic [7:0]  lat [int];
	logic [18:0] wa, pa;
	logic [10:0] sec;
	logic [7:0]  held = 8'h00;
	logic        wact = 1'b0, bz = 1'b0, tog = 1'b0, lo = 1'b0, hi = 1'b0, pset = 1'b0, ok;
	logic        idm  = 1'b0;
	int          step = 0;
	realtime     t_wr, t_bz, t_id;

	initial viol = 1'b0;

	function automatic logic [7:0] rdv(input logic [18:0] a);
		if (bz)
			return {1'b0, tog, 6'h00};
		if (idm && $realtime >= t_id)
		begin
			if (a == 19'h00000)
				return MAKER;
			if (a == 19'h00001)
				return PART;
			if (a == 19'h00002)
				return lo ? 8'hff : 8'hfe;
			if (a == 19'h7fff2)
				return hi ? 8'hff : 8'hfe;
		end
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction : rdv

	// --------------------
	// write decode
	// --------------------
	always @(negedge fl_we_n)
	begin
		wact = !fl_ce_n;
		wa = fl_addr;
		if (step == 7 && wact && lat.num() > 0 && fl_addr[18:8] !== sec)
			viol = 1'b1;
	end

	// a sequence that strays from the codes drops back to the start
	always @(posedge fl_we_n)
	if (wact)
	begin
		t_wr = $realtime;
		if (step == 7)
		begin
			if (lat.num() == 0)
				sec = wa[18:8];
			lat[wa[7:0]] = fl_dq_o;
		end
		else if (step == 2 && wa[14:0] == 15'h5555)
		begin
			step = (fl_dq_o == 8'ha0) ? 7 : (fl_dq_o == 8'h80) ? 3 : 0;
			if (fl_dq_o == 8'h90)
				t_id = $realtime + ID_NS;
			idm = (fl_dq_o == 8'h90) || (idm && fl_dq_o != 8'hf0);
		end
		else if (step == 6 && wa[14:0] == 15'h0000)
		begin
			lo |= fl_dq_o == 8'h00;
			hi |= fl_dq_o == 8'hff;
			step = 0;
			bz = 1'b1;
			t_bz = $realtime + PROG_NS;
		end
		else
		begin
			ok = wa[14:0] == (step % 3 == 1 ? 15'h2aaa : 15'h5555);
			ok &= fl_dq_o == (step == 5 ? 8'h40 : step % 3 == 1 ? 8'h55 : 8'haa);
			step = (ok && step < 6) ? step + 1 : 0;
		end
	end

	// --------------------
	// program timer and reads
	// --------------------
	always #20
	begin
		if (step == 7 && lat.num() > 0 && $realtime - t_wr > BLC_NS)
		begin
			if (!(sec[10:6] == 5'h00 && lo) && !(sec[10:6] == 5'h1f && hi))
				for (int i = 0; i < 256; i++)
					mem[{sec, 8'(i)}] = lat.exists(i) ? lat[i] : 8'hxx;
			lat.delete();
			step = 0;
			bz = 1'b1;
			t_bz = $realtime + PROG_NS;
		end
		if (bz && $realtime >= t_bz)
		begin
			bz = 1'b0;
			pset = 1'b0;
		end
	end

	always @(negedge fl_oe_n or negedge fl_ce_n)
	if (!fl_oe_n && !fl_ce_n && bz)
	begin
		tog = ~tog;
		if (pset && fl_addr !== pa)
			viol = 1'b1;
		pa = fl_addr;
		pset = 1'b1;
	end

	always @(negedge fl_we_n or negedge fl_ce_n or negedge fl_oe_n)
		#1 if (!fl_we_n && !fl_ce_n && !fl_oe_n) viol = 1'b1;

	// a released bus must not keep showing the last byte
	always @(fl_ce_n, fl_oe_n, fl_addr, bz, tog, idm)
	if (!fl_ce_n && !fl_oe_n)
	begin
		fl_dq_i = rdv(fl_addr);
		held = fl_dq_i;
	end
	else
		fl_dq_i = ~held;
endmodule : fsh_flash_model
`default_nettype wire

//--- fsh_host_tb_top.sv
// self-checking bench: host controller driving the behavioural flash
`timescale 1ns/100ps
`default_nettype none
module fsh_host_tb_top;
	localparam logic [7:0] MAKER = 8'h3a; // arbitrary value
	localparam logic [7:0] PART  = 8'h7b; // arbitrary value
	typedef struct {
		logic [2:0]  op;
		logic [18:0] addr;
		logic        e;
		logic        rd;
		logic [7:0]  dat;
	} fsh_row_s;
	logic        mclk, srst, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, rd_ready;
	logic        busy, done, err, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, viol, got_err;
	logic [2:0]  cmd_op;
	logic [18:0] cmd_addr, fl_addr;
	logic [7:0]  wr_data, rd_data, fl_dq_o, fl_dq_i;
	logic [7:0]  rq [$];
	int          err_count = 0, checks_done = 0, n_done = 0, n_err = 0, d0, e0;
	fsh_row_s    rows [9] = '{
		'{3'h2, 19'h00000, 1'b0, 1'b0, 8'h00}, '{3'h0, 19'h00000, 1'b0, 1'b1, MAKER},
		'{3'h0, 19'h00001, 1'b0, 1'b1, PART},  '{3'h0, 19'h00002, 1'b0, 1'b1, 8'hfe},
		'{3'h0, 19'h7fff2, 1'b0, 1'b1, 8'hfe}, '{3'h3, 19'h00000, 1'b0, 1'b0, 8'h00},
		'{3'h0, 19'h00001, 1'b0, 1'b1, 8'hff}, '{3'h6, 19'h00000, 1'b1, 1'b0, 8'h00},
		'{3'h7, 19'h00000, 1'b1, 1'b0, 8'h00}};

	fsh_host #(.ID_WAIT_CYC(20), .PROG_TIMEOUT_CYC(200)) fsh_host_i (.mclk, .srst, .cmd_valid,
		.cmd_ready, .cmd_op, .cmd_addr, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready,
		.rd_data, .busy, .done, .err, .fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_o,
		.fl_dq_oe, .fl_dq_i);
	fsh_flash_model #(.MAKER(MAKER), .PART(PART)) fsh_flash_model_i (.fl_addr, .fl_ce_n,
		.fl_oe_n, .fl_we_n, .fl_dq_o, .fl_dq_i, .viol);

	// --------------------
	// clock, monitor, helpers
	// --------------------
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		if (rd_valid && rd_ready)
			rq.push_back(rd_data);
		if (done === 1'b1)
			n_done++;
		if (err === 1'b1)
			n_err++;
	end

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [7:0] pop();
		return rq.size() ? rq.pop_front() : 8'hxx;
	endfunction : pop

	// bytes follow the pattern index xor 3c so each address is recognisable
	task automatic run(input logic [2:0] op, input logic [18:0] a, input int nb);
		int k;
		d0 = n_done;
		e0 = n_err;
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		for (k = 0; k < 100 && cmd_ready !== 1'b1; k++)
			@(negedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
		for (int i = 0; i < nb; i++)
		begin
			wr_valid = 1'b1;
			wr_data = 8'(i) ^ 8'h3c;
			for (k = 0; k < 100 && wr_ready !== 1'b1; k++)
				@(negedge mclk);
			@(negedge mclk);
		end
		wr_valid = 1'b0;
	endtask : run

	task automatic fin();
		for (int k = 0; k < 20000 && n_done == d0 && n_err == e0; k++)
			@(negedge mclk);
		chk(n_done != d0 || n_err != e0, 1'b1);
		got_err = n_err != e0;
	endtask : fin

	task automatic rdc(input logic [18:0] a, input logic [7:0] x);
		run(3'h0, a, 0);
		fin();
		chk(pop(), x);
	endtask : rdc

	initial
	begin
		#2400000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end

	// --------------------
	// main sequence
	// --------------------
	initial
	begin
		srst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = 3'h0;
		cmd_addr = 19'h00000;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		rd_ready = 1'b1;
		repeat (2) @(negedge mclk);
		srst = 1'b0;
		chk({fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, busy, cmd_ready}, 6'h39);
		foreach (rows[j])
		begin
			run(rows[j].op, rows[j].addr, 0);
			fin();
			chk(got_err, rows[j].e);
			if (rows[j].rd)
				chk(pop(), rows[j].dat);
		end
		run(3'h1, 19'h12300, 256);
		fin();
		chk(got_err, 1'b0);
		rd_ready = 1'b0;
		run(3'h0, 19'h12300, 0);
		fin();
		chk(rq.size(), 0);
		run(3'h0, 19'h123ff, 0);
		fin();
		chk(rd_valid, 1'b1);
		run(3'h0, 19'h12380, 0);
		repeat (40) @(negedge mclk);
		chk({busy, fl_oe_n}, 2'h3);
		rd_ready = 1'b1;
		fin();
		chk(pop(), 8'h3c);
		chk(pop(), 8'hc3);
		chk(pop(), 8'hbc);
		run(3'h4, 19'h00000, 0);
		fin();
		chk(got_err, 1'b0);
		run(3'h1, 19'h00100, 256);
		fin();
		rdc(19'h00105, 8'hff);
		run(3'h2, 19'h00000, 0);
		fin();
		rdc(19'h00002, 8'hff);
		rdc(19'h7fff2, 8'hfe);
		run(3'h3, 19'h00000, 0);
		fin();
		run(3'h5, 19'h00000, 0);
		fin();
		run(3'h2, 19'h00000, 0);
		fin();
		rdc(19'h7fff2, 8'hff);
		run(3'h3, 19'h00000, 0);
		fin();
		run(3'h1, 19'h20000, 1);
		fin();
		chk(got_err, 1'b1);
		for (int k = 0; k < 20000 && busy !== 1'b0; k++)
			@(negedge mclk);
		repeat (200) @(negedge mclk);
		rdc(19'h20000, 8'h3c);
		run(3'h0, 19'h12300, 0);
		repeat (5) @(negedge mclk);
		srst = 1'b1;
		repeat (2) @(negedge mclk);
		srst = 1'b0;
		chk({fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, busy, rd_valid}, 6'h38);
		rdc(19'h123ff, 8'hc3);
		chk(viol, 1'b0);
		summarize();
	end
endmodule : fsh_host_tb_top
`default_nettype wire
